/* File: include/acs_cfg.svh */
// constants for the adc conversion sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// ============================================================
// register byte offsets
`define ACS_CTRL_OFF 12'h000
`define ACS_STAT_OFF 12'h004
`define ACS_RES_OFF 12'h008
`define ACS_PREV_OFF 12'h00c
`define ACS_ACC_OFF 12'h010
`define ACS_THR_OFF 12'h014
`define ACS_ERR_OFF 12'h018
// ============================================================
// control field positions
`define ACS_C_ON 0
`define ACS_C_GO 1
`define ACS_C_CS 2
`define ACS_C_FM 3
`define ACS_C_REPEAT_SAMPLING_BIT 4
`define ACS_C_PREVIOUS_SOURCE_SELECT 5
`define ACS_C_DOUBLE_SAMPLING_BIT 6
`define ACS_C_IE 7
`define ACS_C_TSEL 8
// status field positions
`define ACS_S_DONE 0
`define ACS_S_THR 1
`define ACS_S_MATH 2
`define ACS_S_PEND 3
`define ACS_S_BUSY 4
// ============================================================
// timing: conversion counter reload, one less than the converter clocks per conversion; result justification shift
`define ACS_CONV_CYC 5'h0e
`define ACS_JUST_SH 4
`endif

/* File: include/acs_pkg.sv */
// types for the adc conversion sequencer
package acs_pkg;
  // conversion sequence states
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_DELAY,
    ACS_CONV
  } acs_state_e;
endpackage

/* File: rtl/acs_seq.sv */
// adc conversion sequencer with apb register slave
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_seq #(
  parameter int TRIG_N = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_tick,
  input wire logic sys_tick,
  input wire logic instr_tick,
  input wire logic sleep_mode,
  input wire logic [TRIG_N-1:0] trig_in,
  input wire logic [11:0] sample_data,
  output logic sample_strobe,
  output logic irq_req,
  output logic wake_req
);
  // ============================================================
  // registers
  logic [11:0] ctrl_q; // control bits
  logic done_q; // conversion done flag
  logic thr_q; // threshold flag
  logic math_q; // computation pending
  logic pend_q; // deferred trigger
  logic off_q; // self shut-off after sleep conversion
  logic [11:0] res_q; // result, right justified
  logic [11:0] prev_q; // previous result
  logic [15:0] acc_q; // accumulator
  logic [11:0] thr_lim_q; // threshold limit
  logic [12:0] err_q; // error value
  logic parity_q; // double sample phase
  logic [4:0] cnt_q; // conversion clock counter
  logic [TRIG_N-1:0] trig_q; // trigger history
  acs_pkg::acs_state_e st_q;
  // ============================================================
  // decode
  logic wr, rd_ok, tick, trig_rise, rc_sel, conv_end, sw_go, hw_go;
  logic [1:0] tsel;
  assign wr = psel && penable && pwrite;
  assign rc_sel = ctrl_q[`ACS_C_CS];
  assign tsel = ctrl_q[`ACS_C_TSEL+1:`ACS_C_TSEL];
  // rc clock or divided system clock drive the sequence
  assign tick = rc_sel ? rc_tick : sys_tick;
  assign trig_rise = trig_in[tsel] && !trig_q[tsel];
  assign sw_go = wr && paddr == `ACS_CTRL_OFF && pwdata[`ACS_C_GO];
  // sleeping on the system clock the trigger must wait
  assign hw_go = (trig_rise || pend_q) && !(sleep_mode && !rc_sel);
  assign conv_end = st_q == acs_pkg::ACS_CONV && tick && cnt_q == 5'h00;
  // ============================================================
  // trigger edge history, one flop per source
  genvar gi;
  generate
    for (gi = 0; gi < TRIG_N; gi++) begin : g_trig
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          trig_q[gi] <= 1'b0;
        end else begin
          trig_q[gi] <= trig_in[gi];
        end
      end
    end
  endgenerate
  // ============================================================
  // deferred trigger latch
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (trig_rise && sleep_mode && !rc_sel) begin
      pend_q <= 1'b1;
    end else if (!sleep_mode || rc_sel) begin
      pend_q <= 1'b0; // consumed by hw_go
    end
  end
  // ============================================================
  // control register; go set by software or hardware
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 12'h000;
    end else begin
      if (wr && paddr == `ACS_CTRL_OFF) begin
        ctrl_q <= pwdata[11:0];
      end
      if (ctrl_q[`ACS_C_ON] && hw_go) begin
        ctrl_q[`ACS_C_GO] <= 1'b1;
      end else if (conv_end && !ctrl_q[`ACS_C_REPEAT_SAMPLING_BIT]) begin
        ctrl_q[`ACS_C_GO] <= 1'b0;
      end
    end
  end
  // ============================================================
  // conversion sequence
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= acs_pkg::ACS_IDLE;
      cnt_q <= 5'h00;
    end else if (!ctrl_q[`ACS_C_ON] || off_q) begin
      st_q <= acs_pkg::ACS_IDLE;
    end else begin
      case (st_q)
        acs_pkg::ACS_IDLE: begin
          if (ctrl_q[`ACS_C_GO]) begin
            // rc clock waits an instruction for sleep entry
            st_q <= rc_sel ? acs_pkg::ACS_DELAY
                           : acs_pkg::ACS_CONV;
            cnt_q <= `ACS_CONV_CYC;
          end
        end
        acs_pkg::ACS_DELAY: begin
          if (instr_tick) begin
            st_q <= acs_pkg::ACS_CONV;
          end
        end
        acs_pkg::ACS_CONV: begin
          if (tick) begin
            if (cnt_q == 5'h00) begin
              // repeat mode keeps go set and restarts
              st_q <= acs_pkg::ACS_IDLE;
            end else begin
              cnt_q <= cnt_q - 5'h01;
            end
          end
        end
        default: st_q <= acs_pkg::ACS_IDLE;
      endcase
    end
  end
  assign sample_strobe = conv_end;
  // ============================================================
  // sleep shut-off; enable bit stays set
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      off_q <= 1'b0;
    end else if (!sleep_mode || !ctrl_q[`ACS_C_ON]) begin
      off_q <= 1'b0;
    end else if (conv_end && !ctrl_q[`ACS_C_IE] && !trig_rise) begin
      off_q <= 1'b1;
    end
  end
  // ============================================================
  // results: stored right justified
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      res_q <= 12'h000;
      prev_q <= 12'h000;
      acc_q <= 16'h0000;
      thr_lim_q <= 12'h000;
    end else if (conv_end) begin
      if (!ctrl_q[`ACS_C_PREVIOUS_SOURCE_SELECT]) begin
        prev_q <= res_q;
      end
      res_q <= sample_data;
      acc_q <= acc_q + {4'h0, sample_data};
    end else if (wr) begin
      if (paddr == `ACS_RES_OFF) begin
        res_q <= pwdata[11:0];
      end
      if (paddr == `ACS_ACC_OFF) begin
        acc_q <= pwdata[15:0];
      end
      if (paddr == `ACS_THR_OFF) begin
        thr_lim_q <= pwdata[11:0];
      end
    end
  end
  // ============================================================
  // flags: hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      math_q <= 1'b0;
      thr_q <= 1'b0;
      err_q <= 13'h0000;
      parity_q <= 1'b0;
    end else begin
      if (wr && paddr == `ACS_STAT_OFF) begin
        // write one to clear
        if (pwdata[`ACS_S_DONE]) done_q <= 1'b0;
        if (pwdata[`ACS_S_MATH]) math_q <= 1'b0;
        if (pwdata[`ACS_S_THR]) thr_q <= 1'b0;
      end
      if (conv_end) begin
        done_q <= 1'b1;
        math_q <= 1'b1;
        parity_q <= ctrl_q[`ACS_C_DOUBLE_SAMPLING_BIT] ? !parity_q : 1'b0;
        if (!ctrl_q[`ACS_C_DOUBLE_SAMPLING_BIT] || parity_q) begin
          err_q <= {1'b0, sample_data} - {1'b0, thr_lim_q};
          if (sample_data > thr_lim_q) thr_q <= 1'b1;
        end
      end
    end
  end
  // interrupt request and sleep wake
  assign irq_req = done_q && ctrl_q[`ACS_C_IE];
  assign wake_req = irq_req && sleep_mode;
  // ============================================================
  // apb read path, zero wait states
  logic [31:0] rd_d;
  always_comb begin
    rd_ok = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      `ACS_CTRL_OFF: rd_d = {20'h00000, ctrl_q};
      `ACS_STAT_OFF: rd_d = {27'h0000000, st_q != acs_pkg::ACS_IDLE,
                             pend_q, math_q, thr_q, done_q};
      `ACS_RES_OFF: rd_d = ctrl_q[`ACS_C_FM] ? {20'h00000, res_q}
        : {20'h00000, res_q} << `ACS_JUST_SH;
      `ACS_PREV_OFF: rd_d = {20'h00000, prev_q};
      `ACS_ACC_OFF: rd_d = {16'h0000, acc_q};
      `ACS_THR_OFF: rd_d = {20'h00000, thr_lim_q};
      `ACS_ERR_OFF: rd_d = {19'h00000, err_q};
      default: rd_ok = 1'b0;
    endcase
  end
  assign prdata = rd_d;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;
  // ============================================================
  // assertions: sequencing and completion side effects
  // start conditions shared by both clock choices
  sequence s_start_ok;
    st_q == acs_pkg::ACS_IDLE && ctrl_q[`ACS_C_GO]
      && ctrl_q[`ACS_C_ON] && !off_q;
  endsequence
  // start while the rc clock is selected
  sequence s_rc_start;
    s_start_ok ##0 rc_sel;
  endsequence
  // start while the system clock is selected
  sequence s_sys_start;
    s_start_ok ##0 !rc_sel;
  endsequence
  // rc clock parks one instruction before converting
  property p_rc_delay;
    @(posedge clock) disable iff (!rst_b)
      s_rc_start |=> st_q == acs_pkg::ACS_DELAY;
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("rc start skipped the delay");
  // system clock goes straight into the conversion
  property p_sys_start;
    @(posedge clock) disable iff (!rst_b)
      s_sys_start |=> st_q == acs_pkg::ACS_CONV;
  endproperty
  a_sys_start: assert property (p_sys_start)
    else $error("system clock start did not convert");
  // done flag always follows a conversion end
  property p_done_set;
    @(posedge clock) disable iff (!rst_b)
      conv_end |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set at conversion end");
  // single mode drops go at the end
  property p_go_clear;
    @(posedge clock) disable iff (!rst_b)
      conv_end && !ctrl_q[`ACS_C_REPEAT_SAMPLING_BIT]
        && !(ctrl_q[`ACS_C_ON] && hw_go) |=> !ctrl_q[`ACS_C_GO];
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("go still set after single conversion");
  // repeat mode keeps go so the sequence restarts
  property p_go_hold;
    @(posedge clock) disable iff (!rst_b)
      conv_end && ctrl_q[`ACS_C_REPEAT_SAMPLING_BIT]
        && !(wr && paddr == `ACS_CTRL_OFF) |=> ctrl_q[`ACS_C_GO];
  endproperty
  a_go_hold: assert property (p_go_hold)
    else $error("go dropped in repeat mode");
  // a taken hardware start shows up as go
  property p_hw_go;
    @(posedge clock) disable iff (!rst_b)
      ctrl_q[`ACS_C_ON] && hw_go |=> ctrl_q[`ACS_C_GO];
  endproperty
  a_hw_go: assert property (p_hw_go)
    else $error("trigger did not set go");
  // trigger in sleep on the system clock is held back
  property p_pend_set;
    @(posedge clock) disable iff (!rst_b)
      trig_rise && sleep_mode && !rc_sel |=> pend_q;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("sleeping trigger not latched");
  // old result moves to previous when selected
  property p_prev_copy;
    @(posedge clock) disable iff (!rst_b)
      conv_end && !ctrl_q[`ACS_C_PREVIOUS_SOURCE_SELECT] |=> prev_q == $past(res_q);
  endproperty
  a_prev_copy: assert property (p_prev_copy)
    else $error("previous result not updated");
  // a disabled converter never leaves idle
  property p_off_idle;
    @(posedge clock) disable iff (!rst_b)
      !ctrl_q[`ACS_C_ON] |=> st_q == acs_pkg::ACS_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("sequence ran while disabled");
endmodule

/* File: sim/acs_tb.sv */
// self-checking testbench for the adc conversion sequencer
`timescale 1ns/1ps
`include "acs_cfg.svh"
module testbench;
  // ============================================================
  // stimulus signals
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rc_tick, sys_tick, instr_tick, sleep_mode;
  logic sample_strobe, irq_req, wake_req;
  logic [3:0] trig_in;
  logic [11:0] sample_data;
  logic [2:0] icnt_q; // instruction boundary divider
  logic err_s; // error response taken at the ready edge
  int mismatches, n_checks;
  acs_seq #(.TRIG_N(4)) u_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .sys_tick(sys_tick), .instr_tick(instr_tick),
    .sleep_mode(sleep_mode), .trig_in(trig_in),
    .sample_data(sample_data), .sample_strobe(sample_strobe),
    .irq_req(irq_req), .wake_req(wake_req));
  // ============================================================
  // clock and instruction boundary pulses
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // one boundary every eight cycles, so the rc start delay is visible
  always @(posedge clock) begin
    if (!rst_b) begin
      icnt_q <= 3'h0;
      instr_tick <= 1'b0;
    end else begin
      icnt_q <= icnt_q + 3'h1;
      instr_tick <= (icnt_q == 3'h7);
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // ============================================================
  // apb master: setup, access, hold until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready wait", 32'h1, 32'h0);
      finish_test();
    end
    rd = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input string what, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask
  // poll go until the conversion ends, bounded
  task wait_go();
    int n;
    n = 0;
    do begin
      apb(1'b0, `ACS_CTRL_OFF, 32'h0);
      n++;
    end while (rd[`ACS_C_GO] !== 1'b0 && n < 40);
    chk("go cleared", 32'h0, {31'h0, rd[`ACS_C_GO]});
  endtask
  // ============================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {rc_tick, sys_tick} = 2'h3;
    sleep_mode = 1'b0;
    trig_in = 4'h0;
    sample_data = 12'habc;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rchk("ctrl reset", `ACS_CTRL_OFF, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err_s});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `ACS_THR_OFF, 32'h100);
    apb(1'b1, `ACS_CTRL_OFF, 32'h9);
    apb(1'b1, `ACS_CTRL_OFF, 32'hb);
    wait_go();
    rchk("res right", `ACS_RES_OFF, 32'habc);
    rchk("stat", `ACS_STAT_OFF, 32'h7);
    rchk("err", `ACS_ERR_OFF, 32'h9bc);
    chk("irq masked", 32'h0, {31'h0, irq_req});
    apb(1'b1, `ACS_STAT_OFF, 32'h7);
    sample_data <= 12'h123;
    apb(1'b1, `ACS_CTRL_OFF, 32'h8d);
    apb(1'b1, `ACS_CTRL_OFF, 32'h8f);
    wait_go();
    chk("irq on", 32'h1, {31'h0, irq_req});
    rchk("prev", `ACS_PREV_OFF, 32'habc);
    rchk("acc", `ACS_ACC_OFF, 32'hbdf);
    rchk("err2", `ACS_ERR_OFF, 32'h23);
    apb(1'b1, `ACS_CTRL_OFF, 32'h81);
    rchk("res left", `ACS_RES_OFF, 32'h1230);
    apb(1'b1, `ACS_RES_OFF, 32'h456);
    rchk("res write", `ACS_RES_OFF, 32'h4560);
    sleep_mode <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    chk("wake", 32'h1, {31'h0, wake_req});
    sleep_mode <= 1'b0;
    apb(1'b1, `ACS_STAT_OFF, 32'h7);
    apb(1'b1, `ACS_CTRL_OFF, 32'h109);
    trig_in <= 4'h2;
    rchk("trig go", `ACS_CTRL_OFF, 32'h10b);
    wait_go();
    rchk("trig done", `ACS_STAT_OFF, 32'h7);
    trig_in <= 4'h0;
    apb(1'b1, `ACS_STAT_OFF, 32'h7);
    apb(1'b1, `ACS_CTRL_OFF, 32'h2);
    repeat (40) @(posedge clock);
    rchk("off idle", `ACS_STAT_OFF, 32'h0);
    // system clock trigger while asleep is held back
    apb(1'b1, `ACS_CTRL_OFF, 32'h101);
    sleep_mode <= 1'b1;
    trig_in <= 4'h2;
    repeat (30) @(posedge clock);
    rchk("pend", `ACS_STAT_OFF, 32'h8);
    rchk("pend no go", `ACS_CTRL_OFF, 32'h101);
    sleep_mode <= 1'b0;
    trig_in <= 4'h0;
    wait_go();
    rchk("pend run", `ACS_STAT_OFF, 32'h7);
    apb(1'b1, `ACS_STAT_OFF, 32'h7);
    // rc clock trigger while asleep converts, then shuts off
    apb(1'b1, `ACS_CTRL_OFF, 32'h105);
    sleep_mode <= 1'b1;
    trig_in <= 4'h2;
    repeat (60) @(posedge clock);
    rchk("rc sleep", `ACS_STAT_OFF, 32'h7);
    rchk("on kept", `ACS_CTRL_OFF, 32'h105);
    apb(1'b1, `ACS_CTRL_OFF, 32'h107);
    repeat (40) @(posedge clock);
    rchk("shut off", `ACS_STAT_OFF, 32'h7);
    sleep_mode <= 1'b0;
    trig_in <= 4'h0;
    wait_go();
    apb(1'b1, `ACS_CTRL_OFF, 32'h19);
    apb(1'b1, `ACS_CTRL_OFF, 32'h1b);
    repeat (60) @(posedge clock);
    rchk("repeat_sampling_bit go", `ACS_CTRL_OFF, 32'h1b);
    finish_test();
  end
endmodule
